// [hw/homing_pkg.sv]
package homing_pkg;

  // ==================================================
  // Widths
  localparam int MODE_W = 5;
  localparam int POS_W = 32;
  localparam int SENS_W = 4;
  localparam int CAUSE_W = 2;

  // ==================================================
  // Homing mode codes handled here
  localparam logic [MODE_W-1:0] MODE_NEG_FALL_POS = 5'h0B;
  localparam logic [MODE_W-1:0] MODE_NEG_RISE_NEG = 5'h0C;
  localparam logic [MODE_W-1:0] MODE_NEG_RISE_POS = 5'h0D;
  localparam logic [MODE_W-1:0] MODE_NEG_FALL_NEG = 5'h0E;
  localparam logic [MODE_W-1:0] MODE_RSVD_A = 5'h0F;
  localparam logic [MODE_W-1:0] MODE_RSVD_B = 5'h10;

  // ==================================================
  // Alarm causes
  localparam logic [CAUSE_W-1:0] CAUSE_NONE = 2'h0;
  localparam logic [CAUSE_W-1:0] CAUSE_POS_LIMIT = 2'h1;
  localparam logic [CAUSE_W-1:0] CAUSE_NEG_REPEAT = 2'h2;
  localparam logic [CAUSE_W-1:0] CAUSE_BAD_MODE = 2'h3;

  // ==================================================
  // Reset values
  localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;

  // ==================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_FAST_A = 4'b0001,
    ST_FAST_B = 4'b0010,
    ST_FAST_C = 4'b0011,
    ST_SLOW = 4'b0100,
    ST_INDEX = 4'b0101,
    ST_STOP = 4'b0110,
    ST_FINISH = 4'b0111,
    ST_ALARM = 4'b1000
  } state_t;

  // ==================================================
  // Carriers
  typedef struct packed {
    logic home_switch;
    logic negative_limit;
    logic positive_limit;
    logic index;
  } sensors_t;

  typedef struct packed {
    logic run;
    logic dirPos;
    logic fast;
  } motion_cmd_t;

  // Route of one homing run: direction and edge of each move
  typedef struct packed {
    logic aPos;
    logic aRise;
    logic aToC;
    logic bRise;
    logic bToC;
    logic cPos;
    logic cRise;
    logic slowPos;
    logic slowRise;
  } plan_t;

endpackage

// [hw/in_sync.sv]
`timescale 1ns/1ns
module in_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta_r <= '0;
      dout <= '0;
    end
    else if (clkEn)
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule

// [hw/pos_latch.sv]
`timescale 1ns/1ns
module pos_latch
  import homing_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  // Control
  input wire logic capture,
  input wire logic clear,
  input wire logic [POS_W-1:0] posIn,
  // Held position
  output logic [POS_W-1:0] posOut,
  output logic posValid
);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      posOut <= POS_RESET;
      posValid <= 1'b0;
    end
    else if (clkEn)
    begin
      if (capture)
      begin
        posOut <= posIn;
        posValid <= 1'b1;
      end
      else if (clear)
      begin
        posValid <= 1'b0;
      end
    end
  end

endmodule

// [hw/homing_sequencer.sv]
// What this block does
// - Mode 11 active start: forward, back, slow
// - Mode 11: slow forward to fall, forward index
// - Modes 11-13: first negative limit reverses
// - Modes 11-13: positive or second negative alarms
// - Mode 12 positive side: negative, back out
// - Mode 12: slow negative to rise, index
// - Mode 12 negative side: limit, forward past
// - Mode 12 active start: forward, slow negative
// - Mode 13 positive side: negative, slow forward
// - Mode 13 negative side: limit, rise, back
// - Mode 13 active start: negative, slow forward
// - Mode 14 positive side: negative, return, slow
// - Mode 14 negative side: limit, rise, slow
// - Mode 14 active start: negative, back, slow
// - Mode 14: reverse once, alarm on limits
// - Overshoot on return still continues search
`timescale 1ns/1ns
module homing_sequencer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  // Host request
  input wire logic start,
  input wire logic abort,
  input wire logic [homing_pkg::MODE_W-1:0] mode,
  // Switch and encoder index pins
  input wire homing_pkg::sensors_t sensorPins,
  // Drive side
  input wire logic motionStopped,
  input wire logic [homing_pkg::POS_W-1:0] encoderPos,
  output homing_pkg::motion_cmd_t motionCmd,
  // Status
  output logic busy,
  output logic homeDone,
  output logic homeAlarm,
  output logic [homing_pkg::CAUSE_W-1:0] alarmCause,
  output logic [homing_pkg::POS_W-1:0] homePos,
  output logic homeValid
);
  import homing_pkg::*;

  // ==================================================
  // Route table for each mode and start level
  function automatic plan_t planFor(input logic [MODE_W-1:0] m, input logic active);
    plan_t p;
    p = '0;
    unique case (m)
      // Inactive: seek the zone going negative; active: leave it forward
      MODE_NEG_FALL_POS: p = '{aPos: active, aRise: !active, aToC: active, bRise: 1'b0, bToC: 1'b1,
        cPos: 1'b0, cRise: 1'b1, slowPos: 1'b1, slowRise: 1'b0};
      MODE_NEG_RISE_NEG: p = '{aPos: active, aRise: !active, aToC: !active, bRise: 1'b0, bToC: 1'b0,
        cPos: 1'b1, cRise: 1'b0, slowPos: 1'b0, slowRise: 1'b1};
      MODE_NEG_RISE_POS: p = '{aPos: 1'b0, aRise: 1'b0, aToC: 1'b0, bRise: 1'b1, bToC: 1'b1,
        cPos: 1'b0, cRise: 1'b0, slowPos: 1'b1, slowRise: 1'b1};
      MODE_NEG_FALL_NEG: p = '{aPos: 1'b0, aRise: 1'b0, aToC: 1'b1, bRise: 1'b1, bToC: 1'b0,
        cPos: 1'b1, cRise: 1'b1, slowPos: 1'b0, slowRise: 1'b0};
      default: p = '0;
    endcase
    return p;
  endfunction

  // ==================================================
  // Pin synchronisers
  sensors_t sens;

  in_sync #(
    .WIDTH(SENS_W)
  ) uSync (
    .clk_sys(clk_sys),
    .rst(rst),
    .clkEn(clkEn),
    .din(sensorPins),
    .dout(sens)
  );

  // ==================================================
  // Edge history of the synchronised inputs
  logic homePrev_r;
  logic indexPrev_r;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      homePrev_r <= 1'b0;
      indexPrev_r <= 1'b0;
    end
    else if (clkEn)
    begin
      homePrev_r <= sens.home_switch;
      indexPrev_r <= sens.index;
    end
  end

  logic homeRise;
  logic homeFall;
  logic indexRise;

  assign homeRise = sens.home_switch && !homePrev_r;
  assign homeFall = !sens.home_switch && homePrev_r;
  assign indexRise = sens.index && !indexPrev_r;

  // ==================================================
  // Run state
  state_t state_r;
  state_t state_nxt;
  state_t after_r;
  state_t after_nxt;
  plan_t plan_r;
  plan_t planNow;
  logic negSeen_r;
  logic negSeen_nxt;
  logic [CAUSE_W-1:0] cause_nxt;
  logic capture;
  logic modeOk;
  logic moving;
  logic dirPos;

  // Codes 15 and 16 are reserved; the host must not select them
  assign modeOk = (mode == MODE_NEG_FALL_POS) || (mode == MODE_NEG_RISE_NEG) ||
                  (mode == MODE_NEG_RISE_POS) || (mode == MODE_NEG_FALL_NEG);

  assign moving = (state_r == ST_FAST_A) || (state_r == ST_FAST_B) || (state_r == ST_FAST_C) ||
                  (state_r == ST_SLOW) || (state_r == ST_INDEX);
  // The route is latched on the start edge, so the first command reads it unlatched
  assign planNow = (state_r == ST_IDLE) ? planFor(mode, sens.home_switch) : plan_r;

  // Direction of the move in progress
  always_comb
  begin
    unique case (state_r)
      ST_FAST_A: dirPos = plan_r.aPos;
      ST_FAST_B: dirPos = 1'b1;
      ST_FAST_C: dirPos = plan_r.cPos;
      ST_SLOW, ST_INDEX: dirPos = plan_r.slowPos;
      default: dirPos = 1'b0;
    endcase
  end

  // ==================================================
  // Next-state logic
  always_comb
  begin
    state_nxt = state_r;
    after_nxt = after_r;
    negSeen_nxt = negSeen_r;
    cause_nxt = CAUSE_NONE;
    capture = 1'b0;
    if (abort && (state_r != ST_IDLE) && (state_r != ST_ALARM))
    begin
      // Abort still lets the axis come to rest before going idle
      state_nxt = ST_STOP;
      after_nxt = ST_IDLE;
    end
    else if (moving && sens.positive_limit)
    begin
      state_nxt = ST_ALARM;
      cause_nxt = CAUSE_POS_LIMIT;
    end
    else if (moving && !dirPos && sens.negative_limit)
    begin
      if (negSeen_r)
      begin
        state_nxt = ST_ALARM;
        cause_nxt = CAUSE_NEG_REPEAT;
      end
      else
      begin
        negSeen_nxt = 1'b1;
        state_nxt = ST_STOP;
        after_nxt = ST_FAST_B;
      end
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (start)
          begin
            negSeen_nxt = 1'b0;
            if (modeOk)
            begin
              state_nxt = ST_FAST_A;
            end
            else
            begin
              state_nxt = ST_ALARM;
              cause_nxt = CAUSE_BAD_MODE;
            end
          end
        end
        ST_FAST_A:
        begin
          if (plan_r.aRise ? homeRise : homeFall)
          begin
            state_nxt = ST_STOP;
            after_nxt = plan_r.aToC ? ST_FAST_C : ST_SLOW;
          end
        end
        ST_FAST_B:
        begin
          if (plan_r.bRise ? homeRise : homeFall)
          begin
            state_nxt = ST_STOP;
            after_nxt = plan_r.bToC ? ST_FAST_C : ST_SLOW;
          end
        end
        ST_FAST_C:
        begin
          // Only the edge picked by cRise ends this move, not a level: a narrow zone may be overshot
          if (plan_r.cRise ? homeRise : homeFall)
          begin
            state_nxt = ST_STOP;
            after_nxt = ST_SLOW;
          end
        end
        ST_SLOW:
        begin
          if (plan_r.slowRise ? homeRise : homeFall)
          begin
            state_nxt = ST_INDEX;
          end
        end
        ST_INDEX:
        begin
          // Keep creeping the same way; the first index edge is the nearest one
          if (indexRise)
          begin
            capture = 1'b1;
            state_nxt = ST_STOP;
            after_nxt = ST_FINISH;
          end
        end
        ST_STOP:
        begin
          if (motionStopped)
          begin
            state_nxt = after_r;
          end
        end
        ST_FINISH:
        begin
          state_nxt = ST_IDLE;
        end
        ST_ALARM:
        begin
          if (start)
          begin
            state_nxt = ST_IDLE;
          end
        end
        default:
        begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // ==================================================
  // Sequencer registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      after_r <= ST_IDLE;
      negSeen_r <= 1'b0;
    end
    else if (clkEn)
    begin
      state_r <= state_nxt;
      after_r <= after_nxt;
      negSeen_r <= negSeen_nxt;
    end
  end

  // Route is frozen at start so a mode change mid-run has no effect
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      plan_r <= '0;
    end
    else if (clkEn && (state_r == ST_IDLE) && start)
    begin
      plan_r <= planFor(mode, sens.home_switch);
    end
  end

  // ==================================================
  // Motion command, registered from the next state
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      motionCmd <= '0;
    end
    else if (clkEn)
    begin
      unique case (state_nxt)
        ST_FAST_A: motionCmd <= '{run: 1'b1, dirPos: planNow.aPos, fast: 1'b1};
        ST_FAST_B: motionCmd <= '{run: 1'b1, dirPos: 1'b1, fast: 1'b1};
        ST_FAST_C: motionCmd <= '{run: 1'b1, dirPos: plan_r.cPos, fast: 1'b1};
        ST_SLOW, ST_INDEX: motionCmd <= '{run: 1'b1, dirPos: plan_r.slowPos, fast: 1'b0};
        default:
        begin
          // Dropping run asks the drive to decelerate to rest
          motionCmd <= '0;
        end
      endcase
    end
  end

  // ==================================================
  // Status flags
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      homeDone <= 1'b0;
      homeAlarm <= 1'b0;
      alarmCause <= CAUSE_NONE;
    end
    else if (clkEn)
    begin
      busy <= (state_nxt != ST_IDLE) && (state_nxt != ST_ALARM);
      if (state_nxt == ST_FINISH)
      begin
        homeDone <= 1'b1;
      end
      else if (start && (state_r == ST_IDLE))
      begin
        homeDone <= 1'b0;
      end
      if (state_nxt == ST_ALARM && state_r != ST_ALARM)
      begin
        homeAlarm <= 1'b1;
        alarmCause <= cause_nxt;
      end
      else if (state_nxt != ST_ALARM)
      begin
        homeAlarm <= 1'b0;
        alarmCause <= CAUSE_NONE;
      end
    end
  end

  // ==================================================
  // Home position capture
  pos_latch uLatch (
    .clk_sys(clk_sys),
    .rst(rst),
    .clkEn(clkEn),
    .capture(capture),
    .clear(start && (state_r == ST_IDLE)),
    .posIn(encoderPos),
    .posOut(homePos),
    .posValid(homeValid)
  );

endmodule

// [tb/homing_sequencer_sva.sv]
`timescale 1ns/1ns
module homing_sequencer_sva
  import homing_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  // Host request
  input wire logic start,
  input wire logic abort,
  input wire logic [MODE_W-1:0] mode,
  // Pins and drive
  input wire sensors_t sensorPins,
  input wire logic motionStopped,
  input wire logic [POS_W-1:0] encoderPos,
  input wire motion_cmd_t motionCmd,
  // Status
  input wire logic busy,
  input wire logic homeDone,
  input wire logic homeAlarm,
  input wire logic [CAUSE_W-1:0] alarmCause,
  input wire logic [POS_W-1:0] homePos,
  input wire logic homeValid
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ==================================================
  // Steps
  sequence idle_start;
    start && clkEn && !busy && !homeAlarm;
  endsequence

  // Three edges cover the two synchroniser flops plus the reaction
  sequence pos_limit_held;
    busy && sensorPins.positive_limit ##1 sensorPins.positive_limit [*3];
  endsequence

  // ==================================================
  // Checks
  start_moves_fast_a: assert property (idle_start ##0 (mode >= MODE_NEG_FALL_POS && mode <= MODE_NEG_FALL_NEG)
    |=> busy && motionCmd.run && motionCmd.fast) else $error("first move not fast");
  bad_mode_alarm_a: assert property (idle_start ##0 (mode == MODE_RSVD_A || mode == MODE_RSVD_B)
    |=> homeAlarm && alarmCause == CAUSE_BAD_MODE && !busy) else $error("reserved mode not refused");
  pos_limit_a: assert property (pos_limit_held |-> ##[0:1] (homeAlarm && alarmCause == CAUSE_POS_LIMIT))
    else $error("positive limit did not alarm");
  alarm_halts_a: assert property (homeAlarm |-> !motionCmd.run && !busy && !homeDone)
    else $error("motion during alarm");
  stop_first_a: assert property ($rose(motionCmd.run) |-> $past(motionStopped))
    else $error("move began before rest");
  done_latched_a: assert property ($rose(homeDone) |-> homeValid && !homeAlarm)
    else $error("done without latched home");
  done_idle_a: assert property ($rose(homeDone) |=> !busy && !motionCmd.run)
    else $error("busy after done");
  done_holds_a: assert property (homeDone && !start |=> homeDone)
    else $error("done dropped early");
  index_stops_a: assert property ($rose(homeValid) |-> ##[0:1] !motionCmd.run)
    else $error("no stop at index");
  slow_index_a: assert property ($rose(homeValid) |-> $past(motionCmd.run && !motionCmd.fast))
    else $error("index taken at high speed");
endmodule

bind homing_sequencer homing_sequencer_sva chk (.clk_sys, .rst, .clkEn, .start, .abort, .mode, .sensorPins,
  .motionStopped, .encoderPos, .motionCmd, .busy, .homeDone, .homeAlarm, .alarmCause, .homePos, .homeValid);

// [tb/axis_model.sv]
`timescale 1ns/1ns
module axis_model
  import homing_pkg::*;
(
  // Clock and position preset
  input wire logic clk_sys,
  input wire logic load,
  input wire logic [POS_W-1:0] loadPos,
  // Drive side
  input wire motion_cmd_t motionCmd,
  output sensors_t sensorPins,
  output logic motionStopped,
  output logic [POS_W-1:0] encoderPos
);
  // ==================================================
  // Geometry: switch zone, limits, an index every 64 counts
  localparam int ZONE_LO = 10;
  localparam int ZONE_HI = 210;
  localparam int LIMIT = 2000;
  int pos;
  int restCount;

  // Rest is reported two cycles late, so a sequencer that skips the wait is caught
  always_ff @(posedge clk_sys)
  begin
    if (load)
    begin
      pos <= int'($signed(loadPos));
      restCount <= 2;
    end
    else if (motionCmd.run)
    begin
      pos <= pos + (motionCmd.dirPos ? 1 : -1) * (motionCmd.fast ? 4 : 1);
      restCount <= 0;
    end
    else if (restCount < 2)
      restCount <= restCount + 1;
  end

  assign sensorPins.home_switch = pos >= ZONE_LO && pos <= ZONE_HI;
  assign sensorPins.negative_limit = pos <= -LIMIT;
  assign sensorPins.positive_limit = pos >= LIMIT;
  assign sensorPins.index = (pos & 63) < 4;
  assign motionStopped = restCount == 2;
  assign encoderPos = pos;
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  import homing_pkg::*;
  logic clk_sys, rst, start, load, clkEn, abort;
  logic [MODE_W-1:0] mode;
  logic [POS_W-1:0] loadPos, encoderPos, homePos;
  logic motionStopped, busy, homeDone, homeAlarm, homeValid;
  logic [CAUSE_W-1:0] alarmCause;
  sensors_t sensorPins;
  motion_cmd_t motionCmd;
  logic [15:0] lfsrState;
  logic signed [31:0] delta;
  int r;
  int failCount;
  int samplesChecked;

  homing_sequencer dut (.clk_sys, .rst, .clkEn, .start, .abort, .mode, .sensorPins, .motionStopped,
    .encoderPos, .motionCmd, .busy, .homeDone, .homeAlarm, .alarmCause, .homePos, .homeValid);
  axis_model axis (.clk_sys, .load, .loadPos, .motionCmd, .sensorPins, .motionStopped, .encoderPos);

  // ==================================================
  // Helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Nearest index past the final switch edge in the final search direction
  function automatic int home_of(input int m);
    return m == 11 ? 256 : m == 12 ? 192 : m == 13 ? 64 : 0;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      failCount++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (failCount == 0 && samplesChecked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Load holds four edges so the synchronisers see the new position before start
  task automatic launch(input logic [MODE_W-1:0] m, input int p);
    load <= 1'b1;
    loadPos <= 32'(p);
    repeat (4) @(posedge clk_sys);
    load <= 1'b0;
    start <= 1'b1;
    mode <= m;
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // A run that never ends counts as a mismatch
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 30000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 30000)
      failCount++;
    @(posedge clk_sys);
  endtask

  task automatic run(input logic [MODE_W-1:0] m, input int p);
    launch(m, p);
    wait_idle();
  endtask

  task automatic clear_alarm();
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
  endtask

  // ==================================================
  // Clock, watchdog, sequence
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (90000) @(posedge clk_sys);
    failCount++;
    tally_and_finish();
  end

  initial
  begin
    rst = 1'b1;
    start = 1'b0;
    clkEn = 1'b1;
    abort = 1'b0;
    load = 1'b1;
    mode = 5'h00;
    loadPos = 32'h0000_0000;
    lfsrState = 16'h0045;
    failCount = 0;
    samplesChecked = 0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    // Start on the positive side, the negative side and inside the switch zone
    for (int m = 11; m <= 14; m++)
      for (int c = 0; c < 3; c++)
      begin
        lfsrState = lfsr_next(lfsrState);
        r = int'(lfsrState) % 1500;
        run(MODE_W'(m), c == 0 ? 300 + r : c == 1 ? -300 - r : 30 + r % 150);
        check(homeDone, 1'b1);
        check(homeAlarm, 1'b0);
        check(homeValid, 1'b1);
        delta = $signed(homePos) - home_of(m);
        check(delta >= -8 && delta <= 8, 1'b1);
      end
    // Codes outside the handled range are refused
    for (int m = 15; m <= 17; m++)
    begin
      run(MODE_W'(m), 500);
      check(homeAlarm, 1'b1);
      check(alarmCause, CAUSE_BAD_MODE);
      clear_alarm();
    end
    // Positive limit already active: every mode must raise the limit alarm
    for (int m = 11; m <= 14; m++)
    begin
      run(MODE_W'(m), 2100);
      check(homeAlarm, 1'b1);
      check(alarmCause, CAUSE_POS_LIMIT);
      check(motionCmd.run, 1'b0);
      clear_alarm();
    end
    // Frozen clock enable holds the command; abort stops without finishing
    launch(MODE_W'(11), 1000);
    clkEn <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check(motionCmd.run && motionCmd.fast && !motionCmd.dirPos, 1'b1);
    check(busy, 1'b1);
    clkEn <= 1'b1;
    abort <= 1'b1;
    @(posedge clk_sys);
    abort <= 1'b0;
    wait_idle();
    check(motionCmd.run, 1'b0);
    check(homeDone, 1'b0);
    check(homeValid, 1'b0);
    check(homeAlarm, 1'b0);
    tally_and_finish();
  end
endmodule
